// [core/sdm_monitor.sv]
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sdm_params.svh"

module sdm_monitor #(
	parameter bit          POSITION_VARIANT = 1'b0,
	parameter int unsigned RATE_WIN_CYC     = `SDM_RATE_WIN_CYC,
	parameter int unsigned PULSES_PER_REV   = 8192
) (
	input  wire logic                core_clk_i,
	input  wire logic                arst_n_i,
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [11:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	input  wire sdm_pkg::sdm_pin_t   pins_i,
	input  wire sdm_pkg::sdm_values_t values_i,
	output logic                     irq_o
);
	import sdm_pkg::*;

	localparam logic [31:0] WIN_LAST = 32'(RATE_WIN_CYC - 1);
	// Scaled by the real window so a shortened window still reads r/min
	localparam logic [63:0] RPM_MUL  = (64'h3C * 64'(`SDM_CLK_HZ)) /
		64'(RATE_WIN_CYC);
	localparam logic [31:0] PPR      = 32'(PULSES_PER_REV);

	sdm_state_t st;
	sdm_state_t next_st;

	// ============================================================
	// Combinational view
	sdm_pin_t    pin_new;
	logic [19:0] pin_vec;
	logic [31:0] status_word;
	logic [31:0] pulse_word;
	logic [31:0] item_val;
	logic [31:0] reg_val;
	logic        reg_hit;
	logic [3:0]  ev;
	logic        pulse_edge;
	logic        access;
	logic        wr;
	logic [63:0] rpm_prod;

	always_comb begin
		next_st = st;
		// Three-stage synchroniser; a change counts once stages 2 and 3 agree
		next_st.s1 = pins_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		pin_vec = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
		pin_new = sdm_pin_t'(pin_vec);
		next_st.filt = pin_new;

		// Status word
		status_word = 32'h0000_0000;
		status_word[1] = st.filt.servo_fault_out;
		status_word[2] = values_i.dyn_brake_on;
		status_word[3] = values_i.reverse_mode;
		status_word[4] = st.ctrl[`SDM_CTRL_DISP_SEL] ?
			values_i.torque_limit_on : st.filt.rotation_detect_out;
		status_word[5] = POSITION_VARIANT ?
			st.filt.position_done_out : st.filt.speed_match_out;
		status_word[6] = values_i.mode_switch_on;
		status_word[7] = st.filt.fwd_limit_in;
		status_word[8] = st.filt.rev_limit_in;
		status_word[9] = values_i.motor_power_on;
		status_word[10] = st.filt.enc_out_a;
		status_word[11] = st.filt.enc_out_b;
		status_word[12] = st.filt.enc_out_c;
		status_word[13] = st.filt.phase_u;
		status_word[14] = st.filt.phase_v;
		status_word[15] = st.filt.phase_w;
		status_word[16] = st.filt.servo_on_in |
			st.ctrl[`SDM_CTRL_FORCE_SON];
		status_word[17] = st.filt.p_control_in;
		status_word[18] = st.filt.fwd_travel_stop_in &
			~st.ctrl[`SDM_CTRL_FOT_DIS];
		status_word[19] = st.filt.rev_travel_stop_in &
			~st.ctrl[`SDM_CTRL_ROT_DIS];
		status_word[20] = POSITION_VARIANT ? 1'b0 :
			st.filt.abs_request_in;

		// Pulse input word, position variant only
		pulse_word = 32'h0000_0000;
		if (POSITION_VARIANT) begin
			pulse_word[1] = st.filt.pulse_train_in;
			pulse_word[2] = st.filt.pulse_sign_in;
			pulse_word[3] = st.filt.error_clear_in;
		end

		// Reference pulse count and rate over a fixed window
		pulse_edge = POSITION_VARIANT & pin_new.pulse_train_in &
			~st.filt.pulse_train_in;
		if (pulse_edge) begin
			next_st.ref_cnt = st.ref_cnt + 16'h0001;
		end
		if (st.win_cnt >= WIN_LAST) begin
			next_st.win_cnt = 32'h0000_0000;
			rpm_prod = {32'h0000_0000, st.win_pulses} * RPM_MUL;
			next_st.rate = 32'(rpm_prod / {32'h0000_0000, PPR});
			next_st.win_pulses = {31'h0000_0000, pulse_edge};
		end else begin
			next_st.win_cnt = st.win_cnt + 32'h0000_0001;
			rpm_prod = 64'h0000_0000_0000_0000;
			next_st.win_pulses = st.win_pulses + {31'h0000_0000, pulse_edge};
		end

		// Selected monitor item, readable at any time
		item_val = 32'h0000_0000;
		unique case (sdm_item_t'(st.ctrl[`SDM_CTRL_ITEM_MSB:`SDM_CTRL_ITEM_LSB]))
			SDM_ITEM_SPEED: begin
				item_val = values_i.motor_speed;
			end
			SDM_ITEM_SPEED_REF: begin
				if (!POSITION_VARIANT) begin
					item_val = values_i.speed_ref;
				end
			end
			SDM_ITEM_TORQUE: begin
				item_val = values_i.torque_ref_pct;
			end
			SDM_ITEM_U_PULSES: begin
				item_val = values_i.u_edge_pulses;
			end
			SDM_ITEM_ANGLE: begin
				item_val = values_i.elec_angle;
			end
			SDM_ITEM_STATUS: begin
				item_val = status_word;
			end
			SDM_ITEM_PULSE_IN: begin
				item_val = pulse_word;
			end
			SDM_ITEM_REF_RATE: begin
				if (POSITION_VARIANT) begin
					item_val = st.rate;
				end
			end
			SDM_ITEM_POS_ERR: begin
				if (POSITION_VARIANT) begin
					item_val = st.ctrl[`SDM_CTRL_ERR_SCALE] ?
						32'($signed(values_i.position_error) /
						32'sd`SDM_ERR_DIV) :
						values_i.position_error;
				end
			end
			SDM_ITEM_REF_COUNT: begin
				if (POSITION_VARIANT) begin
					item_val = {16'h0000, st.ref_cnt};
				end
			end
			default: begin
				item_val = 32'h0000_0000;
			end
		endcase

		// Events: alarm rise, travel stop rise, done/match rise, count wrap
		ev[`SDM_INT_ALARM] = pin_new.servo_fault_out & ~st.filt.servo_fault_out;
		ev[`SDM_INT_TRAVEL] = (pin_new.fwd_travel_stop_in &
			~st.filt.fwd_travel_stop_in) | (pin_new.rev_travel_stop_in &
			~st.filt.rev_travel_stop_in);
		ev[`SDM_INT_DONE] = POSITION_VARIANT ?
			(pin_new.position_done_out & ~st.filt.position_done_out) :
			(pin_new.speed_match_out & ~st.filt.speed_match_out);
		ev[`SDM_INT_WRAP] = pulse_edge & (st.ref_cnt == 16'hFFFF);

		// APB slave: one wait state, answer registered
		access = psel_i & penable_i & ~st.pready;
		wr = access & pwrite_i;
		reg_hit = 1'b1;
		reg_val = 32'h0000_0000;
		unique case (paddr_i)
			`SDM_OFS_CTRL:     reg_val = {19'h00000, st.ctrl};
			`SDM_OFS_DATA:     reg_val = item_val;
			`SDM_OFS_STATUS:   reg_val = status_word;
			`SDM_OFS_PULSE:    reg_val = pulse_word;
			`SDM_OFS_INT_STAT: reg_val = {28'h0000000, st.int_stat};
			`SDM_OFS_INT_MASK: reg_val = {28'h0000000, st.int_mask};
			`SDM_OFS_REF_CNT:  reg_val = {16'h0000, st.ref_cnt};
			default:           reg_hit = 1'b0;
		endcase
		next_st.pready = access;
		next_st.pslverr = access & ~reg_hit;
		next_st.prdata = (access & ~pwrite_i & reg_hit) ? reg_val :
			32'h0000_0000;

		next_st.int_stat = st.int_stat;
		if (wr) begin
			unique case (paddr_i)
				`SDM_OFS_CTRL: begin
					next_st.ctrl = pwdata_i[12:0];
				end
				`SDM_OFS_INT_STAT: begin
					next_st.int_stat = st.int_stat & ~pwdata_i[3:0];
				end
				`SDM_OFS_INT_MASK: begin
					next_st.int_mask = pwdata_i[3:0];
				end
				`SDM_OFS_REF_CNT: begin
					next_st.ref_cnt = 16'h0000;
				end
				default: begin
				end
			endcase
		end
		// Set wins over a same-cycle clear
		next_st.int_stat = next_st.int_stat | ev;
		next_st.irq = |(next_st.int_stat & next_st.int_mask);
	end

	// ============================================================
	// State register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
			st.ctrl <= `SDM_CTRL_RST;
			st.int_mask <= `SDM_MASK_RST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o = st.prdata;
	assign pready_o = st.pready;
	assign pslverr_o = st.pslverr;
	assign irq_o = st.irq;

endmodule

// [core/sdm_params.svh]
// Functional notes
// - Item selection and readback work at any time, motor running or not.
// - Item set and status bit meanings follow the speed or position variant.
// - Position variant reports reference pulse train speed in r/min.
// - Torque reference item reads as percent of rated torque.
// - Items give encoder pulses since U-phase edge and electrical angle.
// - Position error in units when scale bit is 0, hundreds when 1.
// - Position variant counts reference pulses, range 0 to 65535.
// - Status bit 5 is speed match or positioning done, per variant.
// - Speed variant status bit 17 shows the multi-purpose control input.
// - Status bits 18 and 19 show travel stops, masked when the disable switches are set.
// - Status bit 16 shows servo-on input or the force servo-on switch.
// - Pulse input word: pulse, sign, clear in bits 1 to 3, rest zero.
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// ============================================================
// Register offsets
`define SDM_OFS_CTRL      12'h000
`define SDM_OFS_DATA      12'h004
`define SDM_OFS_STATUS    12'h008
`define SDM_OFS_PULSE     12'h00C
`define SDM_OFS_INT_STAT  12'h010
`define SDM_OFS_INT_MASK  12'h014
`define SDM_OFS_REF_CNT   12'h018

// ============================================================
// Control register fields
`define SDM_CTRL_ITEM_LSB   0
`define SDM_CTRL_ITEM_MSB   3
`define SDM_CTRL_FORCE_SON  8
`define SDM_CTRL_FOT_DIS    9
`define SDM_CTRL_ROT_DIS    10
`define SDM_CTRL_DISP_SEL   11
`define SDM_CTRL_ERR_SCALE  12
`define SDM_CTRL_RST        13'h0000
`define SDM_MASK_RST        4'h0

// ============================================================
// Interrupt status bits
`define SDM_INT_ALARM  0
`define SDM_INT_TRAVEL 1
`define SDM_INT_DONE   2
`define SDM_INT_WRAP   3

// ============================================================
// Timing
`define SDM_CLK_HZ       100000000
`define SDM_RATE_WIN_US  1000
`define SDM_RATE_WIN_CYC (`SDM_RATE_WIN_US * (`SDM_CLK_HZ / 1000000))
`define SDM_ERR_DIV      100
`define SDM_RPM_FACTOR   (60 * (1000000 / `SDM_RATE_WIN_US))

`endif

// [core/sdm_pkg.sv]
package sdm_pkg;

	// ============================================================
	// Monitor items
	typedef enum logic [3:0] {
		SDM_ITEM_SPEED     = 4'h0,
		SDM_ITEM_SPEED_REF = 4'h1,
		SDM_ITEM_TORQUE    = 4'h2,
		SDM_ITEM_U_PULSES  = 4'h3,
		SDM_ITEM_ANGLE     = 4'h4,
		SDM_ITEM_STATUS    = 4'h5,
		SDM_ITEM_PULSE_IN  = 4'h6,
		SDM_ITEM_REF_RATE  = 4'h7,
		SDM_ITEM_POS_ERR   = 4'h8,
		SDM_ITEM_REF_COUNT = 4'h9
	} sdm_item_t;

	// ============================================================
	// Pins from outside the clock domain
	typedef struct packed {
		logic servo_fault_out;
		logic rotation_detect_out;
		logic speed_match_out;
		logic position_done_out;
		logic fwd_limit_in;
		logic rev_limit_in;
		logic p_control_in;
		logic fwd_travel_stop_in;
		logic rev_travel_stop_in;
		logic servo_on_in;
		logic abs_request_in;
		logic pulse_train_in;
		logic pulse_sign_in;
		logic error_clear_in;
		logic enc_out_a;
		logic enc_out_b;
		logic enc_out_c;
		logic phase_u;
		logic phase_v;
		logic phase_w;
	} sdm_pin_t;

	// ============================================================
	// Values and states from the control loops (same clock)
	typedef struct packed {
		logic [31:0] motor_speed;
		logic [31:0] speed_ref;
		logic [31:0] torque_ref_pct;
		logic [31:0] u_edge_pulses;
		logic [31:0] elec_angle;
		logic [31:0] position_error;
		logic        dyn_brake_on;
		logic        reverse_mode;
		logic        mode_switch_on;
		logic        motor_power_on;
		logic        torque_limit_on;
	} sdm_values_t;

	typedef struct packed {
		logic [19:0] s1;
		logic [19:0] s2;
		logic [19:0] s3;
		sdm_pin_t    filt;
		logic [12:0] ctrl;
		logic [3:0]  int_stat;
		logic [3:0]  int_mask;
		logic [15:0] ref_cnt;
		logic [31:0] win_cnt;
		logic [31:0] win_pulses;
		logic [31:0] rate;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
	} sdm_state_t;

endpackage

// [bench/sdm_keypad.sv]
`timescale 1ns/1ps
module sdm_keypad (
	input  wire logic        clk_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [11:0] paddr_o,
	output logic      [31:0] pwdata_o
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0000_0000;
	end

	// ============================================================
	// Keypad access: setup, then hold until ready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e,
		output logic hung);
		int n;
		n = 0;
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 40);
		r = prdata_i;
		e = pslverr_i;
		hung = (pready_i !== 1'b1);
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// One idle edge so a following call never re-drives in this step
		@(posedge clk_i);
	endtask
endmodule

// [bench/sdm_monitor_asserts.sv]
`timescale 1ns/1ps
module sdm_monitor_asserts #(
	parameter bit POSITION_VARIANT = 1'b0
) (
	input wire logic        core_clk_i,
	input wire logic        arst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic rd;
	logic mapped;
	assign rd = pready_o && !pwrite_i;
	assign mapped = paddr_i inside {12'h000, 12'h004, 12'h008, 12'h00C,
		12'h010, 12'h014, 12'h018};

	// ============================================================
	// Access timing
	ready_lat_a: assert property (
		psel_i && penable_i && !pready_o |=> pready_o)
		else $error("ready late");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	ready_cause_a: assert property (
		pready_o |-> $past(psel_i && penable_i))
		else $error("ready without access");
	rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer");
	err_map_a: assert property (pready_o |-> pslverr_o == !mapped)
		else $error("error flag wrong");

	// ============================================================
	// Unused bits
	stat_unused_a: assert property (rd && paddr_i == 12'h008 |->
		prdata_o[31:21] == 11'h000 && !prdata_o[0]
		&& !(POSITION_VARIANT && prdata_o[20]))
		else $error("status unused bits set");
	pulse_unused_a: assert property (rd && paddr_i == 12'h00C |->
		prdata_o[31:4] == 28'h0 && !prdata_o[0])
		else $error("pulse word unused bits set");
	count_range_a: assert property (rd && paddr_i == 12'h018 |->
		prdata_o[31:16] == 16'h0)
		else $error("ref count above range");
endmodule

bind sdm_monitor sdm_monitor_asserts #(
	.POSITION_VARIANT(POSITION_VARIANT)
) u_sdm_monitor_asserts (
	.core_clk_i(core_clk_i),
	.arst_n_i  (arst_n_i),
	.psel_i    (psel_i),
	.penable_i (penable_i),
	.pwrite_i  (pwrite_i),
	.paddr_i   (paddr_i),
	.prdata_o  (prdata_o),
	.pready_o  (pready_o),
	.pslverr_o (pslverr_o)
);

// [bench/servo_drive_status_monitor_tb_top.sv]
`timescale 1ns/1ps
module servo_drive_status_monitor_tb_top;
	import sdm_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	sdm_pin_t    pins = '0;
	sdm_values_t vals = '0;
	logic [31:0] r;
	logic        e;
	int          fail_count = 0;
	int          checks = 0;

	always #5 clk = ~clk;

	sdm_monitor #(.POSITION_VARIANT(1'b1), .RATE_WIN_CYC(100)) u_sdm_monitor (
		.core_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .pins_i(pins), .values_i(vals), .irq_o(irq));
	sdm_keypad u_sdm_keypad (
		.clk_i(clk), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

	// ============================================================
	// Shared tasks
	task automatic stop_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, exp);
		checks++;
		if (s !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, s);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		logic h;
		u_sdm_keypad.xfer(w, a, d, r, e, h);
		if (h) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(nm, r, exp);
	endtask

	// ============================================================
	// Scenarios
	task automatic t_regs();
		rdc("ctrl", 12'h000, 32'h0);
		rdc("mask", 12'h014, 32'h0);
		rdc("unmapped", 12'h01C, 32'h0);
		chk("unmapped err", {31'h0, e}, 32'h1);
	endtask
	task automatic t_status();
		pins <= 20'hFB615;
		vals.dyn_brake_on <= 1'b1;
		vals.mode_switch_on <= 1'b1;
		repeat (6) @(posedge clk);
		rdc("status", 12'h008, 32'h0007A8F6);
		acc(1'b1, 12'h000, 32'h5);
		rdc("item status", 12'h004, 32'h0007A8F6);
		pins.servo_on_in <= 1'b0;
		acc(1'b1, 12'h000, 32'hB05);
		repeat (6) @(posedge clk);
		rdc("status sel", 12'h008, 32'h0003A8E6);
	endtask
	task automatic t_items();
		vals.torque_ref_pct <= 32'h37;
		vals.position_error <= 32'h3039;
		vals.motor_speed <= 32'h5DC;
		vals.speed_ref <= 32'h3E8;
		vals.u_edge_pulses <= 32'h1234;
		vals.elec_angle <= 32'hB4;
		acc(1'b1, 12'h000, 32'h0);
		rdc("speed", 12'h004, 32'h5DC);
		acc(1'b1, 12'h000, 32'h1);
		rdc("speed ref pos", 12'h004, 32'h0);
		acc(1'b1, 12'h000, 32'h3);
		rdc("u pulses", 12'h004, 32'h1234);
		acc(1'b1, 12'h000, 32'h4);
		rdc("angle", 12'h004, 32'hB4);
		acc(1'b1, 12'h000, 32'h2);
		rdc("torque", 12'h004, 32'h37);
		acc(1'b1, 12'h000, 32'h8);
		rdc("pos err x1", 12'h004, 32'h3039);
		acc(1'b1, 12'h000, 32'h1008);
		rdc("pos err x100", 12'h004, 32'h7B);
	endtask
	task automatic t_pulse();
		pins.pulse_sign_in <= 1'b1;
		pins.error_clear_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			pins.pulse_train_in <= 1'b1;
			repeat (6) @(posedge clk);
			pins.pulse_train_in <= 1'b0;
			repeat (6) @(posedge clk);
		end
		rdc("pulse word", 12'h00C, 32'hC);
		rdc("ref count", 12'h018, 32'h5);
		acc(1'b1, 12'h018, 32'h0);
		rdc("ref count clr", 12'h018, 32'h0);
	endtask
	// Ten pulses per 100-cycle window, 8192 per rev: 73242 r/min
	task automatic t_rate();
		fork
			for (int i = 0; i < 40; i++) begin
				pins.pulse_train_in <= 1'b1;
				repeat (5) @(posedge clk);
				pins.pulse_train_in <= 1'b0;
				repeat (5) @(posedge clk);
			end
			begin
				repeat (250) @(posedge clk);
				acc(1'b1, 12'h000, 32'h7);
				rdc("ref rate", 12'h004, 32'h0001_1E1A);
			end
		join
		acc(1'b1, 12'h000, 32'h9);
		rdc("ref count item", 12'h004, 32'h28);
		acc(1'b1, 12'h000, 32'h6);
		rdc("pulse item", 12'h004, 32'hC);
	endtask
	task automatic t_irq();
		rdc("int stat", 12'h010, 32'h7);
		acc(1'b1, 12'h014, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq on", {31'h0, irq}, 32'h1);
		acc(1'b1, 12'h010, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq off", {31'h0, irq}, 32'h0);
		rdc("int stat w1c", 12'h010, 32'h6);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_status();
		t_items();
		t_pulse();
		t_rate();
		t_irq();
		stop_test();
	end
endmodule
